// ==== pkg/sfc_pkg.sv ====
`default_nettype none
package sfc_pkg;

    // Frame layout and counts
    localparam int FRAME_W = 32;
    localparam int PAY_W = 16;
    localparam int BANK_W = 3;
    localparam int RW_BIT = 7;
    localparam int CRC_DATA_W = 24;
    localparam logic [5:0] FRAME_CNT = 6'h20;
    localparam logic [5:0] CRC_CNT = 6'h18;
    localparam logic [5:0] LAST_DATA_CNT = 6'h17;
    localparam logic [5:0] OVF_CNT = 6'h21;

    // Integrity field
    localparam logic [7:0] CRC_POLY = 8'h2F;
    localparam logic [7:0] CRC_INIT = 8'hFF;
    localparam logic [7:0] CRC_XOR = 8'hFF;
    localparam logic [7:0] PAT_IN = 8'hA5;
    localparam logic [7:0] PAT_OUT = 8'h5A;

    // Address map
    localparam logic [6:0] DEV_CTRL_LO = 7'h01;
    localparam logic [6:0] DEV_CTRL_HI = 7'h0B;
    localparam logic [6:0] BD_CTRL_LO = 7'h10;
    localparam logic [6:0] BD_CTRL_HI = 7'h1D;
    localparam logic [6:0] DEV_STAT_LO = 7'h40;
    localparam logic [6:0] DEV_STAT_HI = 7'h46;
    localparam logic [6:0] BD_STAT_LO = 7'h50;
    localparam logic [6:0] BD_STAT_HI = 7'h5B;
    localparam logic [6:0] FAM_ID_ADDR = 7'h70;
    localparam logic [6:0] MODE_CTRL_ADDR = 7'h01;
    localparam logic [6:0] LIN_CTRL_ADDR = 7'h04;
    localparam logic [6:0] DEVICE_STAT_ADDR = 7'h43;
    localparam logic [6:0] WAKE_LVL_ADDR = 7'h46;

    // Field positions
    localparam int MODE_LSB = 14;
    localparam int LIN_LSB = 0;
    localparam int CRC_FAIL_BIT = 0;
    localparam int SPI_FAIL_BIT = 1;
    localparam int CRC_STAT_BIT = 2;
    localparam logic [1:0] LIN_OFF = 2'h0;
    localparam logic [1:0] LIN_WAKE = 2'h1;

    typedef enum logic [1:0] {
        SFC_NORMAL = 2'b00,
        SFC_SLEEP = 2'b01,
        SFC_STOP = 2'b10,
        SFC_RESET = 2'b11
    } sfc_mode_t;

    typedef struct packed {
        logic valid;
        logic wr;
        logic clr;
        logic [6:0] addr;
        logic [15:0] data;
    } sfc_cmd_t;

    typedef struct packed {
        logic valid;
        logic [6:0] addr;
        logic [15:0] bits;
    } sfc_evt_t;

    typedef struct packed {
        logic valid;
        sfc_mode_t mode;
    } sfc_mode_evt_t;

    function automatic logic is_ctrl(input logic [6:0] a);
        return (a >= DEV_CTRL_LO && a <= DEV_CTRL_HI) || (a >= BD_CTRL_LO && a <= BD_CTRL_HI);
    endfunction : is_ctrl

    function automatic logic is_stat(input logic [6:0] a);
        return (a >= DEV_STAT_LO && a <= DEV_STAT_HI) || (a >= BD_STAT_LO && a <= BD_STAT_HI)
            || (a == FAM_ID_ADDR);
    endfunction : is_stat

    // Hit flag and bank array index of a banked register
    function automatic logic [3:0] bank_of(input logic [6:0] a);
        unique case (a)
            7'h05: return 4'h8;
            7'h0A: return 4'h9;
            7'h14: return 4'hA;
            7'h16: return 4'hB;
            7'h18: return 4'hC;
            7'h1A: return 4'hD;
            7'h1B: return 4'hE;
            7'h1C: return 4'hF;
            default: return 4'h0;
        endcase
    endfunction : bank_of

    // First transmitted bit enters first
    function automatic logic [7:0] crc8_24(input logic [23:0] d);
        logic [7:0] c;
        logic fb;
        c = CRC_INIT;
        for (int i = 0; i < CRC_DATA_W; i++) begin
            fb = c[7] ^ d[i];
            c = {c[6:0], 1'h0};
            if (fb)
            begin
                c = c ^ CRC_POLY;
            end
        end
        return c ^ CRC_XOR;
    endfunction : crc8_24

    function automatic logic [7:0] rev8(input logic [7:0] v);
        return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
    endfunction : rev8

endpackage : sfc_pkg
`default_nettype wire

// ==== rtl/sfc_reg_store.sv ====
`timescale 1ns/10ps
`default_nettype none
module sfc_reg_store #(
    parameter logic [15:0] FAMILY_ID = 16'h0001 // Arbitrary value
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic [6:0] rd_addr_i,
    input wire logic [2:0] rd_bank_i,
    output logic [15:0] rd_data_o,
    output logic [7:0] sif_o,
    input wire sfc_pkg::sfc_cmd_t cmd_i,
    input wire logic spi_set_i,
    input wire logic crc_set_i,
    input wire logic crc_en_i,
    input wire logic [15:0] wake_lvl_i,
    input wire sfc_pkg::sfc_evt_t stat_evt_i,
    input wire sfc_pkg::sfc_mode_evt_t mode_evt_i,
    output logic spi_fail_o,
    output logic crc_fail_o
);
    typedef struct packed {
        logic [31:0][15:0] ctrl;
        logic [7:0][7:0][12:0] bank;
        logic [31:0][15:0] stat;
    } sfc_rf_st_t;

    sfc_rf_st_t q;
    sfc_rf_st_t n;
    logic [3:0] rd_bk;
    logic [3:0] wr_bk;
    logic [4:0] dev_idx;
    logic [1:0] lin;

    assign rd_bk = sfc_pkg::bank_of(rd_addr_i);
    assign wr_bk = sfc_pkg::bank_of(cmd_i.addr);
    assign dev_idx = sfc_pkg::DEVICE_STAT_ADDR[4:0];
    assign spi_fail_o = q.stat[dev_idx][sfc_pkg::SPI_FAIL_BIT];
    assign crc_fail_o = q.stat[dev_idx][sfc_pkg::CRC_FAIL_BIT];
    assign lin = q.ctrl[sfc_pkg::LIN_CTRL_ADDR[4:0]][sfc_pkg::LIN_LSB +: 2];

    always_comb
    begin
        rd_data_o = 16'h0000;
        if (sfc_pkg::is_ctrl(rd_addr_i))
        begin
            rd_data_o = rd_bk[3] ? {q.bank[rd_bk[2:0]][rd_bank_i], rd_bank_i} // R22
                                 : q.ctrl[rd_addr_i[4:0]];
        end
        else if (rd_addr_i == sfc_pkg::WAKE_LVL_ADDR)
        begin
            rd_data_o = wake_lvl_i; // R18
        end
        else if (rd_addr_i == sfc_pkg::FAM_ID_ADDR)
        begin
            rd_data_o = FAMILY_ID; // R18
        end
        else if (sfc_pkg::is_stat(rd_addr_i))
        begin
            rd_data_o = q.stat[rd_addr_i[4:0]];
            if (rd_addr_i == sfc_pkg::DEVICE_STAT_ADDR)
            begin
                rd_data_o[sfc_pkg::CRC_STAT_BIT] = crc_en_i; // R10
            end
        end
        for (int i = 0; i < 6; i++) begin
            sif_o[i] = |q.stat[i];
        end
        sif_o[6] = |q.stat[27:16];
        sif_o[7] = spi_fail_o | crc_fail_o; // R26
    end

    always_comb
    begin
        n = q;
        if (cmd_i.valid && cmd_i.wr && sfc_pkg::is_ctrl(cmd_i.addr))
        begin
            if (wr_bk[3])
            begin
                n.bank[wr_bk[2:0]][cmd_i.data[2:0]] = cmd_i.data[15:3]; // R22
            end
            else
            begin
                n.ctrl[cmd_i.addr[4:0]] = cmd_i.data; // R13
            end
        end
        if (cmd_i.valid && cmd_i.clr && sfc_pkg::is_stat(cmd_i.addr)
            && cmd_i.addr != sfc_pkg::WAKE_LVL_ADDR && cmd_i.addr != sfc_pkg::FAM_ID_ADDR) // R18
        begin
            n.stat[cmd_i.addr[4:0]] = 16'h0000; // R17
        end
        if (mode_evt_i.valid)
        begin
            n.ctrl[sfc_pkg::MODE_CTRL_ADDR[4:0]][sfc_pkg::MODE_LSB +: 2] = mode_evt_i.mode; // R19
            // Stop entry and diagnosis bits left alone
            if (mode_evt_i.mode == sfc_pkg::SFC_SLEEP && lin != sfc_pkg::LIN_OFF
                && lin != sfc_pkg::LIN_WAKE) // R20
            begin
                n.ctrl[sfc_pkg::LIN_CTRL_ADDR[4:0]][sfc_pkg::LIN_LSB +: 2] = sfc_pkg::LIN_WAKE; // R21
            end
        end
        // Hardware sets win over a clear in the same cycle
        if (stat_evt_i.valid && sfc_pkg::is_stat(stat_evt_i.addr)
            && stat_evt_i.addr != sfc_pkg::WAKE_LVL_ADDR && stat_evt_i.addr != sfc_pkg::FAM_ID_ADDR)
        begin
            n.stat[stat_evt_i.addr[4:0]] = n.stat[stat_evt_i.addr[4:0]] | stat_evt_i.bits;
        end
        n.stat[dev_idx][sfc_pkg::CRC_STAT_BIT] = 1'h0;
        if (spi_set_i)
        begin
            n.stat[dev_idx][sfc_pkg::SPI_FAIL_BIT] = 1'h1;
        end
        if (crc_set_i)
        begin
            n.stat[dev_idx][sfc_pkg::CRC_FAIL_BIT] = 1'h1; // R07
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            q <= '0;
        end
        else if (ce_i)
        begin
            q <= n;
        end
    end

endmodule : sfc_reg_store
`default_nettype wire

// ==== rtl/sfc_spi_frame.sv ====
// Summary of operation
// (R01) Bits 24 to 31 of every frame carry an 8-bit integrity field, both ways.
// (R02) CRC8: polynomial 2F, init FF, no reflection, final XOR FF.
// (R03) CRC covers frame bits 0 to 23 only, banked registers too.
// (R04) Response payload bits 8 to 23 hold the register before this frame's write.
// (R05) Read-only access of the device status register skips the integrity check.
// (R06) Host formats the status clear frame for the current CRC setting.
// (R07) With CRC on, a mismatching field sets the CRC error flag.
// (R08) With CRC off, a field other than A5 sets the CRC error flag.
// (R09) Host sends A5 in bits 24 to 31 while CRC is off.
// (R10) With CRC off, output field is 5A; CRC status bit tracks the setting.
// (R11) Addresses 01 to 0B are device control registers.
// (R12) Addresses 10 to 1D are bridge control registers.
// (R13) Control registers: bit 7 low reads, bit 7 high also writes.
// (R14) A written value shows only in a later frame.
// (R15) Addresses 40 to 46 are device status, 70 is the family identifier.
// (R16) Addresses 50 to 5B are bridge status registers.
// (R17) Status registers: bit 7 low reads, bit 7 high returns then clears.
// (R18) Wake level and family identifier registers are never cleared.
// (R19) Mode changes update the mode field to the mode entered.
// (R20) Low-power entry keeps diagnosis bits; stop entry keeps LIN bits.
// (R21) Sleep entry forces LIN bits to wake-capable unless off or wake.
// (R22) Banked registers: payload bits 8 to 10 choose bank, rest written there.
// (R23) Banked read inserts one zero right after the status information field.
// (R24) Bits 6..0 address, bit 7 access type, bits 23..8 payload.
// (R25) Changes take effect only at chip select rising.
// (R26) Status field bit 7 is protocol error OR CRC error.
// (R27) CRC fed in transmission order; a CRC error discards the action.
// (R28) Output CRC computed over final response bits 0 to 23 before bit 24.
`timescale 1ns/10ps
`default_nettype none
module sfc_spi_frame (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic sclk_i,
    input wire logic csn_i,
    input wire logic sdi_i,
    input wire logic crc_en_i,
    input wire logic [15:0] wake_lvl_i,
    input wire sfc_pkg::sfc_evt_t stat_evt_i,
    input wire sfc_pkg::sfc_mode_evt_t mode_evt_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    output sfc_pkg::sfc_cmd_t cfg_cmd_o,
    output logic spi_fail_o,
    output logic crc_fail_o
);
    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_d;
        logic csn_s1;
        logic csn_s2;
        logic csn_d;
        logic sdi_s1;
        logic sdi_s2;
        logic crcen_s1;
        logic crcen_s2;
        logic [15:0] wk_s1;
        logic [15:0] wk_s2;
        logic [5:0] cnt;
        logic [31:0] rx;
        logic [7:0] fld;
        logic sdo;
        logic sdo_en;
        logic clk_err;
        logic spi_set;
        logic crc_set;
        sfc_pkg::sfc_cmd_t cmd;
        logic spi_fail;
        logic crc_fail;
    } sfc_main_st_t;

    localparam sfc_main_st_t ST_RST = '{csn_s1: 1'h1, csn_s2: 1'h1, csn_d: 1'h1, default: '0};

    sfc_main_st_t q;
    sfc_main_st_t n;
    logic rise;
    logic fall;
    logic cs_fall;
    logic cs_rise;
    logic banked;
    logic [3:0] bank_hit;
    logic ro_dev;
    logic field_ok;
    logic [6:0] addr;
    logic [15:0] rd_data;
    logic [7:0] sif;
    logic [23:0] resp;
    logic rf_spi_fail;
    logic rf_crc_fail;

    assign rise = q.sclk_s2 & ~q.sclk_d;
    assign fall = ~q.sclk_s2 & q.sclk_d;
    assign cs_fall = ~q.csn_s2 & q.csn_d;
    assign cs_rise = q.csn_s2 & ~q.csn_d;
    assign addr = q.rx[6:0]; // R24
    assign bank_hit = sfc_pkg::bank_of(addr);
    assign banked = bank_hit[3];
    assign ro_dev = (addr == sfc_pkg::DEVICE_STAT_ADDR) && !q.rx[sfc_pkg::RW_BIT];

    // Stored value only, so this frame's write is not visible yet
    assign resp[7:0] = sif; // R26
    assign resp[23:8] = banked ? {rd_data[14:0], 1'h0} : rd_data; // R04 R14 R23

    // Field compare: first transmitted field bit is the CRC msb
    assign field_ok = q.crcen_s2
        ? (sfc_pkg::rev8(q.rx[31:24]) == sfc_pkg::crc8_24(q.rx[23:0])) // R02 R03 R07 R27
        : (q.rx[31:24] == sfc_pkg::PAT_IN); // R08 R09

    sfc_reg_store u_store (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .rd_addr_i(addr),
        .rd_bank_i(q.rx[10:8]),
        .rd_data_o(rd_data),
        .sif_o(sif),
        .cmd_i(q.cmd),
        .spi_set_i(q.spi_set),
        .crc_set_i(q.crc_set),
        .crc_en_i(q.crcen_s2),
        .wake_lvl_i(q.wk_s2),
        .stat_evt_i(stat_evt_i),
        .mode_evt_i(mode_evt_i),
        .spi_fail_o(rf_spi_fail),
        .crc_fail_o(rf_crc_fail)
    );

    always_comb
    begin
        n = q;
        n.sclk_s1 = sclk_i;
        n.sclk_s2 = q.sclk_s1;
        n.sclk_d = q.sclk_s2;
        n.csn_s1 = csn_i;
        n.csn_s2 = q.csn_s1;
        n.csn_d = q.csn_s2;
        n.sdi_s1 = sdi_i;
        n.sdi_s2 = q.sdi_s1;
        n.crcen_s1 = crc_en_i;
        n.crcen_s2 = q.crcen_s1;
        n.wk_s1 = wake_lvl_i;
        n.wk_s2 = q.wk_s1;
        n.spi_set = 1'h0;
        n.crc_set = 1'h0;
        n.cmd = '0;
        n.spi_fail = rf_spi_fail;
        n.crc_fail = rf_crc_fail;
        if (cs_fall)
        begin
            n.cnt = 6'h00;
            n.rx = 32'h0000_0000;
            n.sdo = resp[0];
            n.sdo_en = 1'h1;
            n.clk_err = q.sclk_s2;
        end
        else if (!q.csn_s2)
        begin
            if (rise)
            begin
                if (q.cnt < sfc_pkg::FRAME_CNT)
                begin
                    n.rx[q.cnt[4:0]] = q.sdi_s2;
                    n.cnt = q.cnt + 6'h01;
                end
                else
                begin
                    n.cnt = sfc_pkg::OVF_CNT;
                end
                if (q.cnt == sfc_pkg::LAST_DATA_CNT)
                begin
                    n.fld = q.crcen_s2 ? sfc_pkg::rev8(sfc_pkg::crc8_24(resp)) // R28 R01
                                       : sfc_pkg::PAT_OUT; // R10
                end
            end
            if (fall && q.cnt < sfc_pkg::FRAME_CNT)
            begin
                n.sdo = (q.cnt < sfc_pkg::CRC_CNT) ? resp[q.cnt[4:0]] : q.fld[q.cnt[2:0]];
            end
        end
        if (cs_rise)
        begin
            n.sdo = 1'h0;
            n.sdo_en = 1'h0;
            if (q.cnt != sfc_pkg::FRAME_CNT || q.clk_err || q.sclk_s2)
            begin
                n.spi_set = 1'h1;
            end
            else if (!field_ok && !ro_dev) // R05
            begin
                n.crc_set = 1'h1; // R27
            end
            else if (q.rx[sfc_pkg::RW_BIT]) // R25
            begin
                n.cmd.valid = 1'h1;
                n.cmd.wr = sfc_pkg::is_ctrl(addr); // R11 R12 R13
                n.cmd.clr = sfc_pkg::is_stat(addr); // R15 R16 R17
                n.cmd.addr = addr;
                n.cmd.data = q.rx[23:8];
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            q <= ST_RST;
        end
        else if (ce_i)
        begin
            q <= n;
        end
    end

    assign sdo_o = q.sdo;
    assign sdo_oe_o = q.sdo_en;
    assign cfg_cmd_o = q.cmd;
    assign spi_fail_o = q.spi_fail;
    assign crc_fail_o = q.crc_fail;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);

    chip_release_a: assert property (ce_i && cs_rise |=> !sdo_oe_o && !sdo_o) // R25
        else $error("output enable not dropped at frame end");
    bad_count_a: assert property (ce_i && cs_rise && q.cnt != sfc_pkg::FRAME_CNT
        |=> q.spi_set && !q.cmd.valid ##1 ce_i [*1] ##0 1'h1)
        else $error("wrong clock count not flagged");
    crc_mismatch_a: assert property (ce_i && cs_rise && q.cnt == sfc_pkg::FRAME_CNT && !q.clk_err
        && !q.sclk_s2 && q.crcen_s2 && !ro_dev
        && sfc_pkg::rev8(q.rx[31:24]) != sfc_pkg::crc8_24(q.rx[23:0])
        |=> q.crc_set && !q.cmd.valid) // R07
        else $error("crc mismatch not flagged or not discarded");
    pattern_check_a: assert property (ce_i && cs_rise && q.cnt == sfc_pkg::FRAME_CNT
        && !q.clk_err && !q.sclk_s2 && !q.crcen_s2 && !ro_dev
        && q.rx[31:24] != sfc_pkg::PAT_IN |=> q.crc_set) // R08
        else $error("bad static pattern not flagged");
    ro_status_a: assert property (ce_i && cs_rise && ro_dev |=> !q.crc_set) // R05
        else $error("read of device status flagged a crc error");
    static_out_a: assert property (ce_i && !q.csn_s2 && !cs_fall && rise
        && q.cnt == sfc_pkg::LAST_DATA_CNT && !q.crcen_s2 |=> q.fld == sfc_pkg::PAT_OUT) // R10
        else $error("static output pattern wrong");
    crc_out_a: assert property (ce_i && !q.csn_s2 && !cs_fall && rise
        && q.cnt == sfc_pkg::LAST_DATA_CNT && q.crcen_s2
        |=> sfc_pkg::rev8(q.fld) == sfc_pkg::crc8_24($past(resp))) // R28
        else $error("output crc wrong");
    write_only_a: assert property (q.cmd.valid |-> q.rx[sfc_pkg::RW_BIT] && $past(cs_rise)) // R13
        else $error("command issued without write bit or outside frame end");
    clear_map_a: assert property (q.cmd.valid && q.cmd.clr |-> sfc_pkg::is_stat(q.cmd.addr)
        && !q.cmd.wr) // R17
        else $error("clear issued to a non-status address");
    cmd_pulse_a: assert property (ce_i && q.cmd.valid |=> !q.cmd.valid) // R25
        else $error("command held longer than one cycle");

    write_seen_c: cover property (q.cmd.valid && q.cmd.wr);
    clear_seen_c: cover property (q.cmd.valid && q.cmd.clr);
    crc_err_c: cover property (q.crc_set);
    banked_rd_c: cover property (cs_rise && banked && q.cnt == sfc_pkg::FRAME_CNT);

endmodule : sfc_spi_frame
`default_nettype wire

// ==== verif/sfc_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module sfc_host_model (
    input wire logic clock_i,
    input wire logic go_i,
    input wire logic [31:0] tx_i,
    input wire logic [5:0] nbits_i,
    input wire logic sdo_i,
    output logic sclk_o,
    output logic csn_o,
    output logic sdi_o,
    output logic [31:0] rx_o,
    output logic done_o
);
    initial
    begin
        sclk_o = 1'h0;
        csn_o = 1'h1;
        sdi_o = 1'h0;
        rx_o = 32'h0;
        done_o = 1'h0;
    end

    // One frame per go pulse; clock stays low outside frames
    always @(posedge clock_i)
    begin
        done_o <= 1'h0;
        if (go_i)
        begin
            csn_o <= 1'h0;
            sdi_o <= tx_i[0];
            repeat (12) @(posedge clock_i);
            for (int i = 0; i < 32; i++)
            begin
                if (i < nbits_i)
                begin
                    rx_o[i] <= sdo_i;
                    sclk_o <= 1'h1;
                    repeat (12) @(posedge clock_i);
                    sclk_o <= 1'h0;
                    sdi_o <= (i < 31) ? tx_i[i + 1] : ~tx_i[31];
                    repeat (13) @(posedge clock_i);
                end
            end
            // Released data line shows the inverse of its last bit
            sdi_o <= ~tx_i[nbits_i - 6'h01];
            csn_o <= 1'h1;
            done_o <= 1'h1;
        end
    end
endmodule : sfc_host_model
`default_nettype wire

// ==== verif/tb_sfc_spi_frame.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_sfc_spi_frame;
    typedef struct packed {
        logic [31:0] val;
        logic [31:0] msk;
        logic crc_on;
        logic fchk;
    } sfc_tb_exp_t;
    localparam logic [31:0] PAY = 32'h00FFFF00;
    logic clock_i = 1'h0;
    logic rstn_i = 1'h0;
    logic go = 1'h0;
    logic crc_en = 1'h1;
    logic [31:0] tx = 32'h0;
    logic [5:0] nb = 6'h20;
    logic [15:0] wake = 16'h0;
    sfc_pkg::sfc_evt_t sev = '0;
    sfc_pkg::sfc_mode_evt_t mev = '0;
    logic sclk, csn, sdi, sdo, sdo_oe, spi_f, crc_f, hdone;
    logic [31:0] rx;
    sfc_pkg::sfc_cmd_t cmd;
    sfc_pkg::sfc_cmd_t c;
    sfc_tb_exp_t e;
    sfc_tb_exp_t rq[$];
    sfc_pkg::sfc_cmd_t cq[$];
    int miscompares = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'h16DA8A1B;
    logic [15:0] d;
    logic [2:0] b;
    logic [6:0] ca [4] = '{7'h02, 7'h0B, 7'h10, 7'h1D};
    logic [6:0] ua [4] = '{7'h00, 7'h0C, 7'h1E, 7'h47};

    always #2.5 clock_i = ~clock_i;

    sfc_host_model host (
        .clock_i(clock_i),
        .go_i(go),
        .tx_i(tx),
        .nbits_i(nb),
        .sdo_i(sdo),
        .sclk_o(sclk),
        .csn_o(csn),
        .sdi_o(sdi),
        .rx_o(rx),
        .done_o(hdone)
    );

    sfc_spi_frame DUT (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .ce_i(1'h1),
        .sclk_i(sclk),
        .csn_i(csn),
        .sdi_i(sdi),
        .crc_en_i(crc_en),
        .wake_lvl_i(wake),
        .stat_evt_i(sev),
        .mode_evt_i(mev),
        .sdo_o(sdo),
        .sdo_oe_o(sdo_oe),
        .cfg_cmd_o(cmd),
        .spi_fail_o(spi_f),
        .crc_fail_o(crc_f)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Field byte in wire order: bit-reversed CRC, or the fixed pattern
    function automatic logic [7:0] fld(input logic [23:0] v, input logic on, input logic out);
        logic [7:0] r;
        logic [7:0] k;
        k = 8'hFF;
        for (int i = 0; i < 24; i++)
            k = {k[6:0], 1'h0} ^ ((k[7] ^ v[i]) ? 8'h2F : 8'h00);
        k = k ^ 8'hFF;
        for (int j = 0; j < 8; j++)
            r[j] = k[7 - j];
        return on ? r : (out ? 8'h5A : 8'hA5);
    endfunction : fld

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        if (miscompares == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    task automatic xfer(input logic [23:0] lo, input logic bad, input logic cx,
                        input logic [31:0] ev, input logic [31:0] em);
        int n;
        rq.push_back('{ev, em, crc_en, nb == 6'h20});
        if (cx)
            cq.push_back('{1'h1, ~lo[6], lo[6], lo[6:0], lo[23:8]});
        tx <= {fld(lo, crc_en, 1'h0) ^ {7'h00, bad}, lo};
        go <= 1'h1;
        @(posedge clock_i);
        go <= 1'h0;
        n = 0;
        while (hdone !== 1'h1 && n < 2000)
        begin
            @(posedge clock_i);
            n++;
        end
        if (n >= 2000)
        begin
            miscompares++;
            results();
        end
        repeat (12) @(posedge clock_i);
    endtask : xfer

    task automatic mode(input sfc_pkg::sfc_mode_t m);
        mev <= '{1'h1, m};
        @(posedge clock_i);
        mev <= '0;
        repeat (6) @(posedge clock_i);
    endtask : mode

    // Response and command watcher
    always @(posedge clock_i)
    begin
        if (hdone === 1'h1)
        begin
            e = rq.pop_front();
            check(rx & e.msk, e.val & e.msk);
            if (e.fchk)
                check({24'h0, rx[31:24]}, {24'h0, fld(rx[23:0], e.crc_on, 1'h1)});
        end
        if (cmd.valid === 1'h1)
        begin
            c = cq.pop_front();
            check({6'h0, cmd.valid, cmd.wr, cmd.clr, cmd.addr, c.wr ? cmd.data : 16'h0},
                  {6'h0, c.valid, c.wr, c.clr, c.addr, c.wr ? c.data : 16'h0});
        end
    end

    initial
    begin
        repeat (2) @(posedge clock_i);
        rstn_i <= 1'h1;
        repeat (8) @(posedge clock_i);
        check({29'h0, sdo_oe, spi_f, crc_f}, 32'h0);
        foreach (ca[i])
        begin
            seed = lfsr(seed);
            d = seed[15:0];
            xfer({d, 1'h1, ca[i]}, 1'h0, 1'h1, 32'h0, PAY);
            xfer({~d, 1'h1, ca[i]}, 1'h0, 1'h1, {8'h0, d, 8'h0}, PAY);
            xfer({16'h0, 1'h0, ca[i]}, 1'h0, 1'h0, {8'h0, ~d, 8'h0}, PAY);
        end
        foreach (ua[i])
            xfer({16'h0, 1'h0, ua[i]}, 1'h0, 1'h0, 32'h0, PAY);
        xfer({16'h0, 1'h0, 7'h43}, 1'h1, 1'h0, 32'h400, 32'h700);
        check({31'h0, crc_f}, 32'h0);
        xfer({16'h1234, 1'h1, 7'h1D}, 1'h1, 1'h0, 32'h0, 32'h0);
        check({31'h0, crc_f}, 32'h1);
        xfer({16'h0, 1'h0, 7'h1D}, 1'h0, 1'h0, {8'h0, ~d, 8'h80}, 32'h00FFFF80);
        xfer({16'h0, 1'h1, 7'h43}, 1'h0, 1'h1, 32'h580, 32'h780);
        check({31'h0, crc_f}, 32'h0);
        nb <= 6'h1F;
        @(posedge clock_i);
        xfer({16'h0, 1'h1, 7'h02}, 1'h0, 1'h0, 32'h0, 32'h0);
        nb <= 6'h20;
        check({31'h0, spi_f}, 32'h1);
        xfer({16'h0, 1'h1, 7'h43}, 1'h0, 1'h1, 32'h680, 32'h780);
        check({31'h0, spi_f}, 32'h0);
        seed = lfsr(seed);
        d = seed[15:0];
        b = seed[18:16];
        xfer({d[15:3], b, 1'h1, 7'h05}, 1'h0, 1'h1, 32'h0, 32'h0);
        xfer({~d[15:3], b ^ 3'h1, 1'h1, 7'h05}, 1'h0, 1'h1, 32'h0, 32'h0);
        xfer({13'h0, b, 1'h0, 7'h05}, 1'h0, 1'h0, {8'h0, d[14:3], b, 9'h0}, PAY);
        crc_en <= 1'h0;
        repeat (8) @(posedge clock_i);
        xfer({16'h0, 1'h0, 7'h43}, 1'h0, 1'h0, 32'h0, 32'h700);
        xfer({16'h0, 1'h1, 7'h1D}, 1'h1, 1'h0, 32'h0, 32'h0);
        check({31'h0, crc_f}, 32'h1);
        xfer({16'h0, 1'h1, 7'h43}, 1'h0, 1'h1, 32'h180, 32'h780);
        crc_en <= 1'h1;
        wake <= seed[31:16];
        sev <= '{1'h1, 7'h40, 16'h0001};
        @(posedge clock_i);
        sev <= '0;
        repeat (8) @(posedge clock_i);
        xfer({16'h0, 1'h1, 7'h40}, 1'h0, 1'h1, 32'h101, 32'h00FFFF01);
        xfer({16'h0, 1'h0, 7'h40}, 1'h0, 1'h0, 32'h0, 32'h00FFFF01);
        xfer({16'h0, 1'h1, 7'h46}, 1'h0, 1'h1, {8'h0, seed[31:16], 8'h0}, PAY);
        xfer({16'h0, 1'h0, 7'h46}, 1'h0, 1'h0, {8'h0, seed[31:16], 8'h0}, PAY);
        xfer({16'h0, 1'h1, 7'h70}, 1'h0, 1'h1, 32'h100, PAY);
        xfer({16'h0, 1'h0, 7'h70}, 1'h0, 1'h0, 32'h100, PAY);
        xfer({16'h0002, 1'h1, 7'h04}, 1'h0, 1'h1, 32'h0, 32'h0);
        mode(sfc_pkg::SFC_STOP);
        xfer({16'h0, 1'h0, 7'h04}, 1'h0, 1'h0, 32'h200, PAY);
        xfer({16'h0, 1'h0, 7'h01}, 1'h0, 1'h0, 32'h00800000, 32'h00C00000);
        mode(sfc_pkg::SFC_SLEEP);
        xfer({16'h0, 1'h0, 7'h04}, 1'h0, 1'h0, 32'h100, PAY);
        xfer({16'h0, 1'h0, 7'h01}, 1'h0, 1'h0, 32'h00400000, 32'h00C00000);
        check(rq.size() + cq.size(), 32'h0);
        results();
    end
endmodule : tb_sfc_spi_frame
`default_nettype wire
